// ---- design/rsr_map.vh ----
`ifndef RSR_MAP_VH
`define RSR_MAP_VH
// ==================================================
// Bus identity
`define RSR_SLAVE_ADDR   7'h68
// ==================================================
// Map locations
`define RSR_LOC_HSEC     5'h00
`define RSR_LOC_SEC      5'h01
`define RSR_LOC_MIN      5'h02
`define RSR_LOC_HOUR     5'h03
`define RSR_LOC_DAY      5'h04
`define RSR_LOC_DATE     5'h05
`define RSR_LOC_MONTH    5'h06
`define RSR_LOC_YEAR     5'h07
`define RSR_LOC_DTRIM    5'h08
`define RSR_LOC_WDOG     5'h09
`define RSR_LOC_ALM1     5'h0A
`define RSR_LOC_FLAGS    5'h0F
`define RSR_LOC_TCOUNT   5'h10
`define RSR_LOC_TCTRL    5'h11
`define RSR_LOC_ATRIM    5'h12
`define RSR_LOC_SQW      5'h13
`define RSR_LOC_ALM2     5'h14
`define RSR_LOC_RAM      5'h19
`define RSR_CAL_LOCS     8
// ==================================================
// Field positions
`define RSR_STOP_BIT     7
`define RSR_OUT_BIT      7
`define RSR_AF2_BIT      2
`define RSR_RATE_MSB     7
`define RSR_RATE_LSB     4
// ==================================================
// Reset values and BCD limits
`define RSR_SQW_RESET    8'h10
`define RSR_RATE_OFF     4'h0
`define RSR_RATE_32K     4'h1
`define RSR_ONE_BCD      8'h01
`define RSR_ZERO_BCD     8'h00
`define RSR_MAX_HSEC     8'h99
`define RSR_MAX_SEC      8'h59
`define RSR_MAX_HOUR     8'h23
`define RSR_MAX_DAY      8'h07
`define RSR_MAX_MONTH    8'h12
`define RSR_MAX_YEAR     8'h99
`define RSR_FEB          8'h02
`define RSR_APR          8'h04
`define RSR_JUN          8'h06
`define RSR_SEP          8'h09
`define RSR_NOV          8'h11
`define RSR_DAYS_28      8'h28
`define RSR_DAYS_29      8'h29
`define RSR_DAYS_30      8'h30
`define RSR_DAYS_31      8'h31
// ==================================================
// Time base
`define RSR_HSEC_DIV     16'd328
`endif

// ---- design/rsr_serial_register_port.v ----
// What this block does
// RQ1: Answer as slave only after start plus the fixed slave address.
// RQ2: Expose 32 byte locations accessed in ascending order per transfer.
// RQ3: First eight locations hold subseconds through year.
// RQ4: Trims, watchdog, alarms, flags, timer, square wave, then user RAM.
// RQ5: Pointer advances by one after each data byte, read or write.
// RQ6: Supply below threshold aborts access and clears pointer.
// RQ7: Supply below threshold ignores inputs; nothing is written.
// RQ8: Calendar kept in BCD with 24-hour hours.
// RQ9: Day of month rolls over for 28, 29, 30 and 31 day months.
// RQ10: Square wave runs at its default rate after power-up.
// RQ11: Bus idle whenever data and clock lines are both high.
// RQ12: Master starts a transfer only on an idle bus.
// RQ13: Data line held steady while clock is high.
// RQ14: Data change during clock high decodes as control condition.
// RQ15: Data falling while clock high is a start.
// RQ16: Data rising while clock high is a stop.
// RQ17: One open-drain pin shared by interrupt, output driver, test; here only the output driver bit drives it.
// RQ18: Separate open-drain pin for the second alarm interrupt.
// RQ19: Ninth bit after each byte is acknowledge, receiver pulls low.
// RQ20: Pointer advances only on an acknowledge clock.
// RQ21: Readable time frozen while pointer is in clock locations.
// RQ22: Master withholds acknowledge after last read byte.
// RQ23: Mismatched address leaves data released until next start.
`timescale 1ns/1ps
`include "rsr_map.vh"

module rsr_serial_register_port #(
  parameter [15:0] HSEC_DIV = `RSR_HSEC_DIV
) (
  input  wire i_ref_clk,
  input  wire i_rst_n,
  input  wire i_scl,
  input  wire i_sda,
  input  wire i_supply_low,
  input  wire i_tick_32k,
  output wire o_sda_out,
  output reg  o_sda_oe,
  output wire o_shared_interrupt_output_pin_out,
  output reg  o_shared_interrupt_output_pin_oe,
  output wire o_second_alarm_interrupt_pin_out,
  output reg  o_second_alarm_interrupt_pin_oe,
  output wire o_test_or_reset_output_pin_out,
  output reg  o_test_or_reset_output_pin_oe,
  output reg  o_square_wave_output
);

  // ==================================================
  // Input synchronisers
  localparam NSYNC = 3;
  wire [NSYNC-1:0] raw_in;
  reg  [NSYNC-1:0] filt;
  reg  [NSYNC-1:0] filt_d;
  assign raw_in = {i_tick_32k, i_sda, i_scl};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
      reg s1;
      reg s2;
      reg s3;
      always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          s1 <= 1'b1;
          s2 <= 1'b1;
          s3 <= 1'b1;
          filt[gi] <= 1'b1;
          filt_d[gi] <= 1'b1;
        end else begin
          s1 <= raw_in[gi];
          s2 <= s1;
          s3 <= s2;
          // Needs two agreeing samples, rejects one-cycle glitches
          if (s2 == s3)
            filt[gi] <= s3;
          filt_d[gi] <= filt[gi];
        end
      end
    end
  endgenerate

  // Supply monitor is a level from outside; two flops suffice
  reg lo1;
  reg supply_low;
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lo1 <= 1'b0;
      supply_low <= 1'b0;
    end else begin
      lo1 <= i_supply_low;
      supply_low <= lo1;
    end
  end

  wire scl_rise = filt[0] & ~filt_d[0];
  wire scl_fall = ~filt[0] & filt_d[0];
  wire clk_hi   = filt[0] & filt_d[0];
  wire start_c  = clk_hi & filt_d[1] & ~filt[1];     // [RQ14] [RQ15]
  wire stop_c   = clk_hi & ~filt_d[1] & filt[1];     // [RQ14] [RQ16]
  wire tb_rise  = filt[2] & ~filt_d[2];

  // ==================================================
  // Serial engine
  localparam [4:0] ST_IDLE = 5'b00001;
  localparam [4:0] ST_RX   = 5'b00010;
  localparam [4:0] ST_RACK = 5'b00100;
  localparam [4:0] ST_TX   = 5'b01000;
  localparam [4:0] ST_TACK = 5'b10000;
  localparam [1:0] K_ADDR  = 2'd0;
  localparam [1:0] K_PTR   = 2'd1;
  localparam [1:0] K_DATA  = 2'd2;

  reg [4:0] state;
  reg [1:0] kind;
  reg [3:0] bitcnt;
  reg [7:0] shreg;
  reg       rd_mode;
  reg [4:0] ptr;
  reg       wr_stb;
  reg [7:0] wr_dat;
  reg [4:0] wr_loc;

  reg [7:0] cal  [0:`RSR_CAL_LOCS-1];
  reg [7:0] snap [0:`RSR_CAL_LOCS-1];
  reg [7:0] ctl  [`RSR_CAL_LOCS:31];

  // Clock locations read from the frozen copy
  wire [7:0] rd_byte = (ptr < `RSR_CAL_LOCS) ? snap[ptr[2:0]]
                                             : ctl[ptr];

  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= ST_IDLE;
      kind <= K_ADDR;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      rd_mode <= 1'b0;
      ptr <= 5'h00;
      o_sda_oe <= 1'b0;
      wr_stb <= 1'b0;
      wr_dat <= 8'h00;
      wr_loc <= 5'h00;
    end else begin
      wr_stb <= 1'b0;
      if (supply_low) begin
        // Abort and forget the pointer; inputs ignored [RQ6] [RQ7]
        state <= ST_IDLE;
        ptr <= 5'h00;
        o_sda_oe <= 1'b0;
      end else if (stop_c) begin
        state <= ST_IDLE;                             // [RQ11] [RQ16]
        o_sda_oe <= 1'b0;
      end else if (start_c) begin
        state <= ST_RX;                               // [RQ15] [RQ1]
        kind <= K_ADDR;
        bitcnt <= 4'h0;
        o_sda_oe <= 1'b0;
      end else begin
        case (state)
          ST_RX: begin
            if (scl_rise) begin
              shreg <= {shreg[6:0], filt[1]};         // [RQ13]
              bitcnt <= bitcnt + 4'h1;
            end else if (scl_fall && bitcnt == 4'h8) begin
              bitcnt <= 4'h0;
              if (kind == K_ADDR) begin
                if (shreg[7:1] == `RSR_SLAVE_ADDR) begin   // [RQ1]
                  rd_mode <= shreg[0];
                  o_sda_oe <= 1'b1;                   // [RQ19]
                  state <= ST_RACK;
                end else begin
                  state <= ST_IDLE;                   // [RQ23]
                end
              end else begin
                if (kind == K_PTR)
                  ptr <= shreg[4:0];
                else begin
                  wr_stb <= 1'b1;
                  wr_dat <= shreg;
                  wr_loc <= ptr;
                end
                o_sda_oe <= 1'b1;                     // [RQ19]
                state <= ST_RACK;
              end
            end
          end
          ST_RACK: begin
            if (scl_fall) begin
              if (kind == K_ADDR && rd_mode) begin
                shreg <= rd_byte;
                o_sda_oe <= ~rd_byte[7];
                state <= ST_TX;
              end else begin
                o_sda_oe <= 1'b0;
                state <= ST_RX;
                if (kind == K_DATA)
                  ptr <= ptr + 5'h01;                 // [RQ5] [RQ20] [RQ2]
                kind <= (kind == K_ADDR) ? K_PTR : K_DATA;
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              if (bitcnt == 4'h7) begin
                bitcnt <= 4'h0;
                o_sda_oe <= 1'b0;
                state <= ST_TACK;
              end else begin
                bitcnt <= bitcnt + 4'h1;
                shreg <= {shreg[6:0], 1'b0};
                o_sda_oe <= ~shreg[6];
              end
            end
          end
          ST_TACK: begin
            if (scl_rise) begin
              ptr <= ptr + 5'h01;                     // [RQ5] [RQ20]
              rd_mode <= ~filt[1];
            end else if (scl_fall) begin
              if (rd_mode) begin
                shreg <= rd_byte;
                o_sda_oe <= ~rd_byte[7];
                state <= ST_TX;
              end else begin
                // No acknowledge: line stays released [RQ22]
                state <= ST_IDLE;
              end
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  assign o_sda_out = 1'b0;

  // ==================================================
  // BCD helpers
  function [8:0] bcd_inc;
    input [7:0] v;
    input [7:0] mx;
    input [7:0] mn;
    begin
      if (v >= mx)
        bcd_inc = {1'b1, mn};
      else if (v[3:0] == 4'h9)
        bcd_inc = {1'b0, v[7:4] + 4'h1, 4'h0};
      else
        bcd_inc = {1'b0, v + 8'h01};
    end
  endfunction

  function [7:0] month_len;
    input [7:0] mon;
    input [7:0] yr;
    reg leap;
    begin
      leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                   : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 ||
                      yr[3:0] == 4'h8);
      if (mon == `RSR_FEB)
        month_len = leap ? `RSR_DAYS_29 : `RSR_DAYS_28;  // [RQ9]
      else if (mon == `RSR_APR || mon == `RSR_JUN ||
               mon == `RSR_SEP || mon == `RSR_NOV)
        month_len = `RSR_DAYS_30;
      else
        month_len = `RSR_DAYS_31;
    end
  endfunction

  // ==================================================
  // Calendar counting
  reg [15:0] presc;
  reg [7:0]  next_cal [0:`RSR_CAL_LOCS-1];
  reg [8:0]  r;
  reg        c;
  integer    k;
  integer    j;
  wire hsec_tick = tb_rise && (presc == HSEC_DIV - 16'd1);

  always @* begin
    for (k = 0; k < `RSR_CAL_LOCS; k = k + 1)
      next_cal[k] = cal[k];
    r = 9'h000;
    c = hsec_tick & ~cal[1][`RSR_STOP_BIT];
    if (c) begin                                      // [RQ8]
      r = bcd_inc(cal[0], `RSR_MAX_HSEC, `RSR_ZERO_BCD);
      c = r[8];
      next_cal[0] = r[7:0];
    end
    if (c) begin
      r = bcd_inc({1'b0, cal[1][6:0]}, `RSR_MAX_SEC, `RSR_ZERO_BCD);
      c = r[8];
      next_cal[1] = {cal[1][7], r[6:0]};
    end
    if (c) begin
      r = bcd_inc({1'b0, cal[2][6:0]}, `RSR_MAX_SEC, `RSR_ZERO_BCD);
      c = r[8];
      next_cal[2] = {cal[2][7], r[6:0]};
    end
    if (c) begin
      // 24-hour scale; century bits kept, they step on year wrap
      r = bcd_inc({2'b00, cal[3][5:0]}, `RSR_MAX_HOUR,
                  `RSR_ZERO_BCD);                     // [RQ8]
      c = r[8];
      next_cal[3] = {cal[3][7:6], r[5:0]};
    end
    if (c) begin
      r = bcd_inc({5'h00, cal[4][2:0]}, `RSR_MAX_DAY, `RSR_ONE_BCD);
      next_cal[4] = {cal[4][7:3], r[2:0]};
      r = bcd_inc({2'b00, cal[5][5:0]},
                  month_len(cal[6], cal[7]), `RSR_ONE_BCD);  // [RQ9]
      c = r[8];
      next_cal[5] = {cal[5][7:6], r[5:0]};
    end
    if (c) begin
      r = bcd_inc({3'b000, cal[6][4:0]}, `RSR_MAX_MONTH,
                  `RSR_ONE_BCD);
      c = r[8];
      next_cal[6] = {cal[6][7:5], r[4:0]};
    end
    if (c) begin
      r = bcd_inc(cal[7], `RSR_MAX_YEAR, `RSR_ZERO_BCD);
      next_cal[7] = r[7:0];
      next_cal[3][7:6] = cal[3][7:6] + {1'b0, r[8]};
    end
  end

  // Time locations at the head of the map [RQ3]
  wire freeze = (state != ST_IDLE) && (ptr < `RSR_CAL_LOCS);
  wire cal_wr = wr_stb && (wr_loc < `RSR_CAL_LOCS);

  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      presc <= 16'h0000;
      for (j = 0; j < `RSR_CAL_LOCS; j = j + 1) begin
        cal[j] <= `RSR_ZERO_BCD;
        snap[j] <= `RSR_ZERO_BCD;
      end
    end else begin
      // A time write restarts the divider chain
      if (cal_wr)
        presc <= 16'h0000;
      else if (hsec_tick)
        presc <= 16'h0000;
      else if (tb_rise)
        presc <= presc + 16'h0001;
      for (j = 0; j < `RSR_CAL_LOCS; j = j + 1) begin
        if (cal_wr && wr_loc[2:0] == j[2:0])
          cal[j] <= wr_dat;
        else
          cal[j] <= next_cal[j];
        // Readers see a stable snapshot mid-transfer [RQ21]
        if (!freeze)
          snap[j] <= next_cal[j];
      end
    end
  end

  // ==================================================
  // Control and user locations [RQ4]
  generate
    for (gi = `RSR_CAL_LOCS; gi < 32; gi = gi + 1) begin : g_ctl
      always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n)
          ctl[gi] <= (gi == `RSR_LOC_SQW) ? `RSR_SQW_RESET : 8'h00;
        else if (wr_stb && wr_loc == gi)
          ctl[gi] <= wr_dat;                          // [RQ2] [RQ7]
      end
    end
  endgenerate

  // ==================================================
  // Square wave and open-drain pins
  reg  [11:0] sq_div;
  wire [3:0]  rate = ctl[`RSR_LOC_SQW][`RSR_RATE_MSB:`RSR_RATE_LSB];
  wire [3:0]  rate_sel = rate - 4'h2;

  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sq_div <= 12'h000;
      o_square_wave_output <= 1'b0;
      o_shared_interrupt_output_pin_oe <= 1'b0;
      o_second_alarm_interrupt_pin_oe <= 1'b0;
      o_test_or_reset_output_pin_oe <= 1'b0;
    end else begin
      if (tb_rise)
        sq_div <= sq_div + 12'h001;
      // Defaults to the raw time base until reprogrammed [RQ10]
      if (rate == `RSR_RATE_OFF)
        o_square_wave_output <= 1'b0;
      else if (rate == `RSR_RATE_32K)
        o_square_wave_output <= filt[2];
      else
        o_square_wave_output <= sq_div[rate_sel];
      // Low output driver level pulls the shared pin [RQ17]
      o_shared_interrupt_output_pin_oe <=
        ~ctl[`RSR_LOC_DTRIM][`RSR_OUT_BIT];
      o_second_alarm_interrupt_pin_oe <=
        ctl[`RSR_LOC_FLAGS][`RSR_AF2_BIT];           // [RQ18]
      o_test_or_reset_output_pin_oe <= supply_low;
    end
  end

  assign o_shared_interrupt_output_pin_out = 1'b0;
  assign o_second_alarm_interrupt_pin_out = 1'b0;
  assign o_test_or_reset_output_pin_out = 1'b0;

endmodule

// ---- verification/rsr_port_props.sv ----
`timescale 1ns/1ps
// ====================
// Port checker
module rsr_port_props (
  input wire i_ref_clk,
  input wire i_rst_n,
  input wire i_scl,
  input wire i_supply_low,
  input wire o_sda_out,
  input wire o_sda_oe,
  input wire o_shared_interrupt_output_pin_out,
  input wire o_shared_interrupt_output_pin_oe,
  input wire o_second_alarm_interrupt_pin_out,
  input wire o_second_alarm_interrupt_pin_oe,
  input wire o_test_or_reset_output_pin_out,
  input wire o_test_or_reset_output_pin_oe
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);
  property p_oe_chg;
    $changed(o_sda_oe) && !i_supply_low |-> !i_scl;
  endproperty
  a_oe_chg: assert property (p_oe_chg)
    else $error("sda drive moved with clock high");
  property p_ack_rise;
    $rose(o_sda_oe) |-> !i_scl && !$past(i_scl, 3);
  endproperty
  a_ack_rise: assert property (p_ack_rise)
    else $error("sda drive rose too soon after clock fall");
  property p_oe_fall;
    $fell(o_sda_oe) && !i_supply_low |-> !$past(i_scl, 3);
  endproperty
  a_oe_fall: assert property (p_oe_fall)
    else $error("sda release too soon after clock fall");
  property p_sup_rel;
    i_supply_low [*6] |-> !o_sda_oe;
  endproperty
  a_sup_rel: assert property (p_sup_rel)
    else $error("sda driven during low supply");
  property p_rst_pin;
    $rose(i_supply_low) |-> ##[1:5] o_test_or_reset_output_pin_oe;
  endproperty
  a_rst_pin: assert property (p_rst_pin)
    else $error("reset pin not pulled on low supply");
  property p_od_zero;
    !(o_sda_out | o_shared_interrupt_output_pin_out
      | o_second_alarm_interrupt_pin_out | o_test_or_reset_output_pin_out);
  endproperty
  a_od_zero: assert property (p_od_zero)
    else $error("open drain pin drives high");
  property p_shr_chg;
    $changed(o_shared_interrupt_output_pin_oe) && $past(i_rst_n, 3)
      |-> !i_scl;
  endproperty
  a_shr_chg: assert property (p_shr_chg)
    else $error("shared pin moved outside a write");
  property p_alm_chg;
    $changed(o_second_alarm_interrupt_pin_oe) && $past(i_rst_n, 3)
      |-> !i_scl;
  endproperty
  a_alm_chg: assert property (p_alm_chg)
    else $error("alarm pin moved outside a write");
endmodule

bind rsr_serial_register_port rsr_port_props u_props (
  .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_scl(i_scl),
  .i_supply_low(i_supply_low), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
  .o_shared_interrupt_output_pin_out(o_shared_interrupt_output_pin_out),
  .o_shared_interrupt_output_pin_oe(o_shared_interrupt_output_pin_oe),
  .o_second_alarm_interrupt_pin_out(o_second_alarm_interrupt_pin_out),
  .o_second_alarm_interrupt_pin_oe(o_second_alarm_interrupt_pin_oe),
  .o_test_or_reset_output_pin_out(o_test_or_reset_output_pin_out),
  .o_test_or_reset_output_pin_oe(o_test_or_reset_output_pin_oe)
);

// ---- verification/rsr_bus_master.sv ----
`timescale 1ns/1ps
// ====================
// Two-wire bus master
module rsr_bus_master (
  input  wire  i_clk,
  input  wire  i_sda,
  output logic o_scl,
  output logic o_sda_pull
);
  // Long low phase covers the slave's sync lag
  localparam int T_LO = 10;
  localparam int T_HI = 6;
  initial begin
    o_scl = 1'h1;
    o_sda_pull = 1'h0;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  task automatic bus_start();
    o_sda_pull = 1'h0;
    wt(4);
    o_scl = 1'h1;
    wt(4);
    o_sda_pull = 1'h1;
    wt(4);
    o_scl = 1'h0;
    wt(4);
  endtask
  task automatic bus_stop();
    o_sda_pull = 1'h1;
    wt(4);
    o_scl = 1'h1;
    wt(4);
    o_sda_pull = 1'h0;
    wt(4);
  endtask
  task automatic bus_bit(input logic b, output logic r);
    o_sda_pull = !b;
    wt(T_LO - 4);
    o_scl = 1'h1;
    wt(T_HI / 2);
    r = i_sda;
    wt(T_HI / 2);
    o_scl = 1'h0;
    wt(4);
  endtask
  task automatic bus_byte(input logic [7:0] tx, input logic b9,
                          output logic [7:0] rx, output logic r9);
    for (int i = 7; i >= 0; i--) begin
      bus_bit(tx[i], rx[i]);
    end
    bus_bit(b9, r9);
  endtask
endmodule

// ---- verification/tb_rtc_serial_register_port.sv ----
`timescale 1ns/1ps
// ====================
// Testbench
module tb_rtc_serial_register_port;
  logic clk;
  logic rst_n;
  logic supply_low;
  logic tick;
  logic scl;
  logic pull;
  wire  sda;
  wire  sda_oe;
  wire  shr_oe;
  wire  alm_oe;
  wire  trst_oe;
  wire  square_wave_output;
  int   n_mismatch;
  int   compares;
  // Pull-up on the shared data wire
  assign sda = !(sda_oe | pull);

  rsr_serial_register_port #(.HSEC_DIV(16'h0002)) DUT (
    .i_ref_clk(clk), .i_rst_n(rst_n), .i_scl(scl), .i_sda(sda),
    .i_supply_low(supply_low), .i_tick_32k(tick),
    .o_sda_out(), .o_sda_oe(sda_oe),
    .o_shared_interrupt_output_pin_out(),
    .o_shared_interrupt_output_pin_oe(shr_oe),
    .o_second_alarm_interrupt_pin_out(),
    .o_second_alarm_interrupt_pin_oe(alm_oe),
    .o_test_or_reset_output_pin_out(),
    .o_test_or_reset_output_pin_oe(trst_oe),
    .o_square_wave_output(square_wave_output)
  );
  rsr_bus_master u_master (
    .i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_pull(pull)
  );

  // ====================
  // Checks and bus tasks
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic wr(input logic [4:0] ptr, input logic [31:0] d);
    logic [7:0] rx;
    logic       a;
    u_master.bus_start();
    u_master.bus_byte(8'hD0, 1'h1, rx, a);
    chk("addr ack", 8'h00, {7'h00, a});
    u_master.bus_byte({3'h0, ptr}, 1'h1, rx, a);
    chk("ptr ack", 8'h00, {7'h00, a});
    for (int i = 3; i >= 0; i--) begin
      u_master.bus_byte(d[i*8 +: 8], 1'h1, rx, a);
      chk("data ack", 8'h00, {7'h00, a});
    end
    u_master.bus_stop();
  endtask
  task automatic rd_cur(input logic [31:0] exp);
    logic [7:0] rx;
    logic       a;
    u_master.bus_start();
    u_master.bus_byte(8'hD1, 1'h1, rx, a);
    chk("read addr ack", 8'h00, {7'h00, a});
    for (int i = 3; i >= 0; i--) begin
      u_master.bus_byte(8'hFF, i == 0, rx, a);
      chk("read byte", exp[i*8 +: 8], rx);
    end
    u_master.bus_stop();
  endtask
  task automatic rd(input logic [4:0] ptr, input logic [31:0] exp);
    logic [7:0] rx;
    logic       a;
    u_master.bus_start();
    u_master.bus_byte(8'hD0, 1'h1, rx, a);
    u_master.bus_byte({3'h0, ptr}, 1'h1, rx, a);
    rd_cur(exp);
  endtask
  task automatic tick_run();
    repeat (4) begin
      tick = !tick;
      u_master.wt(10);
      chk("square wave", {7'h00, tick}, {7'h00, square_wave_output});
    end
  endtask

  // ====================
  // Scenarios
  task automatic sc_ram_pins();
    chk("shared oe", 8'h01, {7'h00, shr_oe});
    chk("alarm2 oe", 8'h00, {7'h00, alm_oe});
    wr(5'h19, 32'hA55AC33C);
    rd(5'h19, 32'hA55AC33C);
    wr(5'h08, 32'h80000000);
    wr(5'h0F, 32'h04000000);
    chk("shared oe", 8'h00, {7'h00, shr_oe});
    chk("alarm2 oe", 8'h01, {7'h00, alm_oe});
  endtask
  task automatic sc_wrap();
    wr(5'h1E, 32'h11224530);
    rd(5'h1E, 32'h11224530);
  endtask
  task automatic sc_bad_addr();
    logic [7:0] rx;
    logic       a;
    u_master.bus_start();
    u_master.bus_byte(8'hD2, 1'h1, rx, a);
    chk("foreign addr", 8'h01, {7'h00, a});
    u_master.bus_byte(8'h00, 1'h1, rx, a);
    chk("ignored byte", 8'h01, {7'h00, a});
    u_master.bus_stop();
  endtask
  task automatic sc_supply();
    logic [7:0] rx;
    logic       a;
    u_master.bus_start();
    u_master.bus_byte(8'hD0, 1'h1, rx, a);
    u_master.bus_byte(8'h1A, 1'h1, rx, a);
    supply_low = 1'h1;
    u_master.wt(10);
    chk("reset pin oe", 8'h01, {7'h00, trst_oe});
    u_master.bus_byte(8'h99, 1'h1, rx, a);
    chk("low supply ack", 8'h01, {7'h00, a});
    u_master.bus_stop();
    supply_low = 1'h0;
    u_master.wt(10);
    rd_cur(32'h45300000);
    rd(5'h1A, 32'h5AC33C00);
  endtask
  task automatic sc_calendar();
    // Month, year, start date, next date, next month
    logic [39:0] tbl [5] = '{40'h0224282902, 40'h0224290103,
                             40'h0223280103, 40'h0423300105,
                             40'h0123310102};
    logic [39:0] r;
    for (int i = 0; i < 5; i++) begin
      r = tbl[i];
      wr(5'h00, 32'h99595923);
      wr(5'h04, {8'h01, r[23:16], r[39:32], r[31:24]});
      tick_run();
      rd(5'h03, {16'h0002, r[15:0]});
    end
  endtask

  // ====================
  // Run
  initial begin
    clk = 1'h0;
    forever #5 clk = !clk;
  end
  initial begin
    rst_n = 1'h0;
    supply_low = 1'h0;
    tick = 1'h0;
    n_mismatch = 0;
    compares = 0;
    repeat (20) @(negedge clk);
    rst_n = 1'h1;
    u_master.wt(8);
    sc_ram_pins();
    sc_wrap();
    sc_bad_addr();
    sc_supply();
    sc_calendar();
    report_and_stop();
  end
  // Cuts a hang short
  initial begin
    #900000;
    n_mismatch++;
    $display("[ERR] run time limit exp done got hang");
    report_and_stop();
  end
endmodule
